// ===== hdl/mcr_defines.svh
// Purpose: Offsets, field positions and reset values for the counter read-out block
// Assumes: Byte-wide register port at the documented offsets
// Notes: Included by its bare name
`ifndef MCR_DEFINES_SVH
`define MCR_DEFINES_SVH
`define MCR_OFF_CTRL 8'h79
`define MCR_OFF_TRIG 8'h7A
`define MCR_OFF_DATA3 8'h80
`define MCR_OFF_DATA2 8'h81
`define MCR_OFF_DATA1 8'h82
`define MCR_OFF_DATA0 8'h83
`define MCR_CTRL_PORT 8'h1C
`define MCR_CTRL_DROP 8'h1D
`define MCR_BIT_OVF 31
`define MCR_BIT_VALID 30
`define MCR_PORT_BASE1 9'h020
`define MCR_PORT_BASE2 9'h040
`define MCR_DROP_BASE 9'h100
`define MCR_DROP_LAST 9'h105
`define MCR_RESET_BYTE 8'h00
`endif

// ===== hdl/mcr_pkg.sv
// Purpose: Types for the counter read-out block
// Assumes: Nothing beyond the defines header
// Notes: Types only
package mcr_pkg;
    typedef logic [7:0] mcr_byte_t;
    typedef logic [29:0] mcr_count_t;
    typedef logic [15:0] mcr_drop_t;
endpackage

// ===== hdl/mcr_counter_read.sv
// Purpose: Statistics counters of a three-port switch with indirect read-out
// Assumes: Byte register port synchronous to sys_clk; event inputs one-cycle pulses
// Notes: Only the port counter being read-cleared loses an event that arrives in the cycle of its capture
`timescale 1ns/1ns
`include "mcr_defines.svh"

// How it works
// - Drop counters: 16-bit, reset zero, upper reserved
// - TX drop counts at 0x100..0x102
// - RX drop counts at 0x103..0x105
// - 0x1D then offset returns drop count low
// - Write to 0x7A starts the read
// - Bit 31 shows overflow of read counter
// - Bit 30 valid, bits 29:24 at 0x80
// - Remaining bytes at 0x81, 0x82, 0x83
// - Port counters clear when read
// - Drop counters keep value when read
// - No flags for drop counters
// - Port banks at 0x00, 0x20, 0x40
// - Port word: overflow, valid, 30-bit count
module mcr_counter_read #(
    parameter int NUM_PORTS = 3,
    parameter int BANK_SIZE = 32
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Register port
    input wire logic regWrite,
    input wire logic regRead,
    input wire mcr_pkg::mcr_byte_t regAddr,
    input wire mcr_pkg::mcr_byte_t regWdata,
    output mcr_pkg::mcr_byte_t regRdata,
    // Statistic events, one bit per counter of each port
    input wire logic [NUM_PORTS*BANK_SIZE-1:0] portEvent,
    input wire logic [NUM_PORTS-1:0] txDropEvent,
    input wire logic [NUM_PORTS-1:0] rxDropEvent
);
    import mcr_pkg::*;

    localparam int NCNT = NUM_PORTS * BANK_SIZE;

    mcr_count_t portCnt_q [NCNT];
    logic [NCNT-1:0] portOvf_q;
    mcr_drop_t dropCnt_q [2*NUM_PORTS];
    mcr_byte_t ctrl_q;
    mcr_byte_t trig_q;
    logic [31:0] data_q;
    mcr_byte_t rdata_q;

    logic [8:0] selAddr;
    logic trigger;
    logic selPort;
    logic selDrop;
    int portIdx;
    int dropIdx;

    // Index of a port counter from the nine-bit indirect address
    function automatic int portIndex(input logic [8:0] a);
        int p;
        p = (a >= `MCR_PORT_BASE2) ? 2 : ((a >= `MCR_PORT_BASE1) ? 1 : 0);
        return p * BANK_SIZE + int'(a[4:0]);
    endfunction

    assign trigger = regWrite && regAddr == `MCR_OFF_TRIG;
    assign selAddr = {ctrl_q[0], regWdata};
    assign selPort = trigger && selAddr < 9'(NCNT) && ctrl_q == `MCR_CTRL_PORT;
    assign selDrop = trigger && ctrl_q == `MCR_CTRL_DROP
        && selAddr >= `MCR_DROP_BASE && selAddr <= `MCR_DROP_LAST;
    assign portIdx = portIndex(selAddr);
    assign dropIdx = int'(selAddr - `MCR_DROP_BASE);

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ctrl_q <= `MCR_RESET_BYTE;
            trig_q <= `MCR_RESET_BYTE;
        end else if (regWrite) begin
            if (regAddr == `MCR_OFF_CTRL) begin
                ctrl_q <= regWdata;
            end
            if (regAddr == `MCR_OFF_TRIG) begin
                trig_q <= regWdata;
            end
        end
    end

    // Per-port counters; a read clear drops a same-cycle event, accepted trade-off
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            for (int i = 0; i < NCNT; i++) begin
                portCnt_q[i] <= '0;
            end
            portOvf_q <= '0;
        end else begin
            for (int i = 0; i < NCNT; i++) begin
                if (selPort && portIdx == i) begin
                    portCnt_q[i] <= '0;
                    portOvf_q[i] <= 1'b0;
                end else if (portEvent[i]) begin
                    portCnt_q[i] <= portCnt_q[i] + 30'h1;
                    if (&portCnt_q[i]) begin
                        portOvf_q[i] <= 1'b1;
                    end
                end
            end
        end
    end

    // Drop counters wrap silently and are never cleared by a read
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            for (int i = 0; i < 2*NUM_PORTS; i++) begin
                dropCnt_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                if (txDropEvent[i]) begin
                    dropCnt_q[i] <= dropCnt_q[i] + 16'h1;
                end
                if (rxDropEvent[i]) begin
                    dropCnt_q[NUM_PORTS+i] <= dropCnt_q[NUM_PORTS+i] + 16'h1;
                end
            end
        end
    end

    // Snapshot of the whole counter so the four bytes agree
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            data_q <= 32'h0000_0000;
        end else if (selPort) begin
            data_q <= {portOvf_q[portIdx], 1'b1, portCnt_q[portIdx]};
        end else if (selDrop) begin
            data_q <= {16'h0000, dropCnt_q[dropIdx]};
        end else if (trigger) begin
            data_q <= 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rdata_q <= `MCR_RESET_BYTE;
        end else if (regRead) begin
            case (regAddr)
                `MCR_OFF_CTRL: rdata_q <= ctrl_q;
                `MCR_OFF_TRIG: rdata_q <= trig_q;
                `MCR_OFF_DATA3: rdata_q <= data_q[31:24];
                `MCR_OFF_DATA2: rdata_q <= data_q[23:16];
                `MCR_OFF_DATA1: rdata_q <= data_q[15:8];
                `MCR_OFF_DATA0: rdata_q <= data_q[7:0];
                default: rdata_q <= `MCR_RESET_BYTE;
            endcase
        end
    end

    assign regRdata = rdata_q;

    property p_clear;
        @(posedge sys_clk) disable iff (!resetn)
        selPort |=> portCnt_q[$past(portIdx)] == 30'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("port counter not cleared");

    property p_keep;
        @(posedge sys_clk) disable iff (!resetn)
        selDrop && !txDropEvent[0] && dropIdx == 0 |=> dropCnt_q[0] == $past(dropCnt_q[0]);
    endproperty
    a_keep: assert property (p_keep) else $error("drop counter changed on read");

    property p_valid;
        @(posedge sys_clk) disable iff (!resetn)
        selPort |=> data_q[`MCR_BIT_VALID];
    endproperty
    a_valid: assert property (p_valid) else $error("valid flag missing");

    property p_ovf;
        @(posedge sys_clk) disable iff (!resetn)
        selPort |=> data_q[`MCR_BIT_OVF] == $past(portOvf_q[portIdx]);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag wrong");

    property p_drophi;
        @(posedge sys_clk) disable iff (!resetn)
        selDrop |=> data_q[31:16] == 16'h0000;
    endproperty
    a_drophi: assert property (p_drophi) else $error("drop word upper bits set");

    property p_snap;
        @(posedge sys_clk) disable iff (!resetn)
        !trigger |=> $stable(data_q);
    endproperty
    a_snap: assert property (p_snap) else $error("snapshot changed without trigger");

    property p_byte0;
        @(posedge sys_clk) disable iff (!resetn)
        regRead && regAddr == `MCR_OFF_DATA0 |=> regRdata == $past(data_q[7:0]);
    endproperty
    a_byte0: assert property (p_byte0) else $error("byte 0 read wrong");

    property p_dropval;
        @(posedge sys_clk) disable iff (!resetn)
        selDrop |=> data_q[15:0] == $past(dropCnt_q[dropIdx]);
    endproperty
    a_dropval: assert property (p_dropval) else $error("drop value wrong");

    property p_hi;
        @(posedge sys_clk) disable iff (!resetn)
        regRead && regAddr == `MCR_OFF_DATA3 |=> regRdata == $past(data_q[31:24]);
    endproperty
    a_hi: assert property (p_hi) else $error("flag byte read wrong");

    property p_refuse;
        @(posedge sys_clk) disable iff (!resetn)
        trigger && !selPort && !selDrop |=> data_q == 32'h0000_0000;
    endproperty
    a_refuse: assert property (p_refuse) else $error("refused trigger left data");

    property p_hold;
        @(posedge sys_clk) disable iff (!resetn)
        !regRead |=> $stable(regRdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data changed without read");

    property p_ovfclr;
        @(posedge sys_clk) disable iff (!resetn)
        selPort |=> !portOvf_q[$past(portIdx)];
    endproperty
    a_ovfclr: assert property (p_ovfclr) else $error("overflow flag not cleared");
endmodule

// ===== bench/tb.sv
// Purpose: Self-checking bench for the counter read-out block
// Assumes: Register strobes are one-cycle pulses, read data lands a cycle later
// Notes: Overflow of a 30-bit count is out of reach in a short run
`timescale 1ns/1ns
`include "mcr_defines.svh"
module tb;
    import mcr_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    mcr_byte_t regAddr = 8'h00;
    mcr_byte_t regWdata = 8'h00;
    mcr_byte_t regRdata;
    logic [101:0] ev = '0;
    int n_fail = 0;
    int checked = 0;
    logic [31:0] w;
    mcr_counter_read mcr_counter_read_inst (.sys_clk(sys_clk), .resetn(resetn),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .portEvent(ev[95:0]), .txDropEvent(ev[98:96]),
        .rxDropEvent(ev[101:99]));
    always #10 sys_clk = ~sys_clk;
    task automatic complete_run();
        $display("Counts: n_fail=%0d checked=%0d", n_fail, checked);
        if (n_fail == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmpb(input mcr_byte_t got, input mcr_byte_t exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Idle edge after each write so the strobe is never set twice in one step
    task automatic wr(input mcr_byte_t a, input mcr_byte_t d);
        regWrite = 1'b1;
        regAddr = a;
        regWdata = d;
        @(posedge sys_clk) #1 regWrite = 1'b0;
        @(posedge sys_clk) #1;
    endtask
    task automatic rd(input mcr_byte_t a, output mcr_byte_t d);
        regRead = 1'b1;
        regAddr = a;
        @(posedge sys_clk) #1 regRead = 1'b0;
        @(posedge sys_clk) #1 d = regRdata;
    endtask
    // Trigger always follows a fresh control write
    task automatic trig(input mcr_byte_t c, input mcr_byte_t off);
        wr(`MCR_OFF_CTRL, c);
        wr(`MCR_OFF_TRIG, off);
    endtask
    task automatic rdword(output logic [31:0] v);
        rd(`MCR_OFF_DATA3, v[31:24]);
        rd(`MCR_OFF_DATA2, v[23:16]);
        rd(`MCR_OFF_DATA1, v[15:8]);
        rd(`MCR_OFF_DATA0, v[7:0]);
    endtask
    // Per-port read; a clear valid flag means start again from the flag byte
    task automatic rdport(output logic [31:0] v);
        rdword(v);
        if (v[`MCR_BIT_VALID] !== 1'b1) begin
            rdword(v);
        end
    endtask
    // Gaps between pulses keep every event distinct
    task automatic pulse(input int b, input int n);
        repeat (n) begin
            ev[b] = 1'b1;
            @(posedge sys_clk) #1 ev[b] = 1'b0;
            @(posedge sys_clk) #1;
        end
    endtask
    task automatic t_reset();
        mcr_byte_t b;
        cmpb(regRdata, `MCR_RESET_BYTE);
        rd(`MCR_OFF_CTRL, b);
        cmpb(b, `MCR_RESET_BYTE);
        rdword(w);
        cmp(w, 32'h0000_0000);
        trig(`MCR_CTRL_DROP, 8'h00);
        rdword(w);
        cmp({16'h0000, w[15:0]}, 32'h0000_0000);
    endtask
    task automatic t_port();
        for (int p = 0; p < 3; p++) begin
            pulse(p * 32 + 14, p + 3);
            trig(`MCR_CTRL_PORT, 8'(p * 32 + 14));
            rdport(w);
            cmp(w, 32'h4000_0000 | 32'(p + 3));
            cmp({w[31], 31'h0}, 32'h0000_0000);
            trig(`MCR_CTRL_PORT, 8'(p * 32 + 14));
            rdport(w);
            cmp(w, 32'h4000_0000);
        end
        pulse(31, 1);
        trig(`MCR_CTRL_PORT, 8'h1F);
        rdport(w);
        cmp(w, 32'h4000_0001);
    endtask
    task automatic t_drop();
        for (int i = 0; i < 6; i++) begin
            pulse(96 + i, i + 1);
        end
        for (int i = 0; i < 6; i++) begin
            trig(`MCR_CTRL_DROP, 8'(i));
            rdword(w);
            cmp({16'h0000, w[15:0]}, 32'(i + 1));
            cmp({30'h0, w[31:30]}, 32'h0000_0000);
            trig(`MCR_CTRL_DROP, 8'(i));
            rdword(w);
            cmp({16'h0000, w[15:0]}, 32'(i + 1));
        end
    endtask
    task automatic t_snapshot();
        mcr_byte_t b;
        pulse(0, 2);
        trig(`MCR_CTRL_PORT, 8'h00);
        pulse(0, 3);
        rdport(w);
        cmp(w, 32'h4000_0002);
        rd(`MCR_OFF_DATA3, b);
        cmpb(b, 8'h40);
        trig(`MCR_CTRL_PORT, 8'h00);
        rdport(w);
        cmp(w, 32'h4000_0003);
        rd(8'h55, b);
        cmpb(b, 8'h00);
    endtask
    // Reset in mid-run must wipe counters, control and read data
    task automatic t_midreset();
        mcr_byte_t b;
        pulse(96, 2);
        pulse(14, 1);
        rd(`MCR_OFF_CTRL, b);
        cmpb(b, `MCR_CTRL_PORT);
        resetn = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 resetn = 1'b1;
        cmpb(regRdata, `MCR_RESET_BYTE);
        rd(`MCR_OFF_CTRL, b);
        cmpb(b, `MCR_RESET_BYTE);
        trig(`MCR_CTRL_DROP, 8'h00);
        rdword(w);
        cmp({16'h0000, w[15:0]}, 32'h0000_0000);
        trig(`MCR_CTRL_PORT, 8'h0E);
        rdport(w);
        cmp(w, 32'h4000_0000);
    endtask
    // Triggers with a bad bank or offset must zero the snapshot
    task automatic t_refuse();
        mcr_byte_t b;
        pulse(97, 1);
        trig(`MCR_CTRL_DROP, 8'h01);
        rdword(w);
        cmp({16'h0000, w[15:0]}, 32'h0000_0001);
        trig(`MCR_CTRL_PORT, 8'h60);
        rdword(w);
        cmp(w, 32'h0000_0000);
        trig(`MCR_CTRL_DROP, 8'h01);
        trig(`MCR_CTRL_DROP, 8'h06);
        rdword(w);
        cmp(w, 32'h0000_0000);
        trig(`MCR_CTRL_DROP, 8'h01);
        trig(8'h33, 8'h05);
        rdword(w);
        cmp(w, 32'h0000_0000);
        rd(`MCR_OFF_CTRL, b);
        cmpb(b, 8'h33);
        rd(`MCR_OFF_TRIG, b);
        cmpb(b, 8'h05);
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        #1 resetn = 1'b1;
        t_reset();
        t_port();
        t_drop();
        t_snapshot();
        t_midreset();
        t_refuse();
        complete_run();
    end
    // Run needs well under a thousand cycles; this allows twenty thousand
    initial begin
        #400000;
        n_fail++;
        complete_run();
    end
endmodule
